// ---- bdl_fifo.sv ----
// Reply byte buffer with registered ready and flush
`timescale 1ns/10ps
module bdl_fifo
  import bdl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  // Clock, reset and flush
  input logic         clk,
  input logic         rst,
  input logic         flush,
  // Streams
  bdl_stream_if.snk   in_s,
  bdl_stream_if.src   out_s
);
  localparam int         AW      = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        ready;
  } bdl_fifo_s;

  bdl_fifo_s st;
  bdl_fifo_s nx;
  logic      push;
  logic      pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == LAST_C) ? '0 : p + AW'(1);
  endfunction

  assign push        = in_s.valid && st.ready;
  assign pop         = out_s.ready && (st.count != '0);
  assign in_s.ready  = st.ready;
  assign out_s.valid = (st.count != '0);
  assign out_s.data  = st.mem[st.rptr];

  always_comb
  begin
    nx = st;
    if (push)
    begin
      nx.mem[st.wptr] = in_s.data;
      nx.wptr         = step(st.wptr);
    end
    if (pop)
      nx.rptr = step(st.rptr);
    nx.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      nx.wptr  = '0;
      nx.rptr  = '0;
      nx.count = '0;
    end
    nx.ready = (nx.count != FULL_C);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st       <= '0;
      st.ready <= 1'b1;
    end
    else
      st <= nx;
  end
endmodule

// ---- bdl_host_model.sv ----
// Debug pod model: starts every bit time and issues the rate probe
`timescale 1ns/10ps
module bdl_host_model
  import bdl_pkg::*;
(
  // Clock
  input  wire logic  ref_clk,
  // Shared pin and target drive
  input  wire logic  pin,
  input  wire logic  tgt_oe,
  input  wire logic  tgt_out,
  // Host drive
  output logic       host_oe,
  output logic       host_out,
  // Status
  output logic       sending,
  output logic       rd_done,
  output logic       rd_ok,
  output logic [7:0] rd_data
);
  initial
  begin
    host_oe  = 1'b0;
    host_out = 1'b1;
    sending  = 1'b0;
    rd_done  = 1'b0;
    rd_ok    = 1'b0;
    rd_data  = 8'h00;
  end

  task automatic drive(input logic oe, input logic v);
    host_oe  = oe;
    host_out = v;
  endtask

  // Top n bits of b; t is ref cycles per debug cycle
  task automatic send_bits(input logic [7:0] b, input int n, input int t);
    int lo;
    sending = 1'b1;
    for (int i = 7; i > 7 - n; i--)
    begin
      @(negedge ref_clk);
      drive(1'b1, 1'b0);
      lo = (b[i] ? 4 : 13) * t;
      repeat (lo) @(negedge ref_clk);
      host_out = 1'b1;
      repeat (16 * t - lo - 1) @(negedge ref_clk);
    end
    drive(1'b0, 1'b1);
    sending = 1'b0;
  endtask

  // Speedup position is judged with slack for the asynchronous start
  task automatic read_byte();
    int sp;
    rd_ok = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge ref_clk);
      drive(1'b1, 1'b0);
      sp = 0;
      for (int k = 1; k <= 22; k++)
      begin
        @(negedge ref_clk);
        if (k == 2)
          host_oe = 1'b0;
        if (k == 10)
          rd_data[i] = pin;
        if (tgt_oe === 1'b1 && tgt_out === 1'b1 && sp == 0)
          sp = k;
      end
      if (rd_data[i] ? (sp < 8 || sp > 12) : (sp < 15 || sp > 19))
        rd_ok = 1'b0;
    end
    rd_done = 1'b1;
    @(negedge ref_clk);
    rd_done = 1'b0;
  endtask

  task automatic probe(output int len);
    @(negedge ref_clk);
    drive(1'b1, 1'b0);
    repeat (140) @(negedge ref_clk);
    host_out = 1'b1;
    @(negedge ref_clk);
    drive(1'b0, 1'b1);
    len = 0;
    repeat (200)
    begin
      @(negedge ref_clk);
      if (tgt_oe === 1'b1 && tgt_out === 1'b0)
        len++;
    end
  endtask
endmodule

// ---- bdl_link.sv ----
// Bit-level target logic of the single-wire background debug link
`timescale 1ns/10ps
// Notes on behaviour
// - All fields travel most significant bit first
// - Nominal bit time is sixteen debug cycles
// - Timeout after 512 debug cycles without edge
// - Timeout drops partial command, probe state untouched
// - Source select picks bus or alternate clock
// - Bit start seen three ref clocks after pin goes low
// - Host bits sampled ten cycles after start
// - Target stays off pin while host sends
// - Logic one: speedup pulse at cycle seven
// - Logic zero: low thirteen cycles, then speedup
// - Rate probe answered with timed low pulse
// - Pin level at reset picks halted start
// - Halt-only commands refused while application runs
// - Memory and status commands accepted anytime
// - Link works without a prior target reset
// - Watchdog held off while halted
// - Background request wakes stop and wait
// - Host waits sixteen cycles for access
module bdl_link
  import bdl_pkg::*;
(
  // Clock and reset
  input  logic       ref_clk,
  input  logic       rst,
  // Debug pin
  input  logic       debug_pin_in,
  output logic       debug_pin_out,
  output logic       debug_pin_oe,
  // Debug clock selection
  input  logic       debug_clock_source_select,
  input  logic       alt_clk_tick,
  // Processor state
  input  logic       halted,
  output logic       start_halted,
  output logic       watchdog_disable,
  output logic       wake_request,
  // Received bytes
  output logic [7:0] rx_data,
  output logic       rx_valid,
  output logic       rx_cmd,
  output logic       cmd_rejected,
  input  logic       cmd_done,
  output logic       timeout_abort,
  // Reply bytes
  input  logic [7:0] tx_data,
  input  logic       tx_valid,
  output logic       tx_ready
);

  typedef struct packed {
    logic [2:0]       sync;
    logic             level;
    logic [1:0]       mode_cnt;
    logic             start_halted;
    bdl_state_e       state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic [7:0]       shift;
    logic [2:0]       nbits;
    logic             tx_active;
    logic             pop;
    logic             pin_out;
    logic             pin_oe;
    logic [7:0]       rx_data;
    logic             rx_valid;
    logic             rx_cmd;
    logic             cmd_first;
    logic             discard;
    logic             cmd_rejected;
    logic             wake_request;
    logic             timeout_abort;
    logic             watchdog_disable;
    logic             flush;
  } bdl_link_s;

  bdl_link_s st;
  bdl_link_s nx;
  logic      dtick;
  logic      fall;

  bdl_stream_if #(.W(BYTE_BITS)) tx_in ();
  bdl_stream_if #(.W(BYTE_BITS)) tx_out ();

  // True on the debug tick that completes cycle k since the bit start
  function automatic logic hit(input logic [CNT_W-1:0] c,
                               input logic [CNT_W-1:0] k,
                               input logic             t);
    return t && (c == k - 10'h001);
  endfunction

  // Register and trace commands need the processor halted
  function automatic logic halt_only(input logic [7:0] code);
    return !code[7];
  endfunction

  assign dtick = debug_clock_source_select ? alt_clk_tick : 1'b1;
  // Filtered level must be high before and low now, so a glitch
  // shorter than two samples never opens a bit
  assign fall  = st.level && !st.sync[1] && !st.sync[2];

  assign tx_in.valid = tx_valid;
  assign tx_in.data  = tx_data;
  assign tx_ready    = tx_in.ready;
  assign tx_out.ready = st.pop;

  // Replies are queued while the host spends its access delay
  bdl_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_reply_fifo (
    .clk   (ref_clk),
    .rst   (rst),
    .flush (st.flush),
    .in_s  (tx_in),
    .out_s (tx_out)
  );

  always_comb
  begin
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    rx_byte = {st.shift[6:0], st.level};
    tx_byte = st.tx_active ? st.shift : tx_out.data;
    nx = st;
    nx.pop           = 1'b0;
    nx.rx_valid      = 1'b0;
    nx.cmd_rejected  = 1'b0;
    nx.wake_request  = 1'b0;
    nx.timeout_abort = 1'b0;
    nx.flush         = 1'b0;
    nx.sync          = {st.sync[1:0], debug_pin_in};
    if (st.sync[1] == st.sync[2])
      nx.level = st.sync[2];
    nx.watchdog_disable = halted;
    // Strap is taken from the second stage: by the third edge after reset
    // it has held the pin for two edges, while the third still shows reset
    if (st.mode_cnt != MODE_SETTLE)
    begin
      nx.mode_cnt     = st.mode_cnt + 2'h1;
      nx.start_halted = !st.sync[1];
    end
    if (dtick && st.cnt != CNT_MAX)
      nx.cnt = st.cnt + 10'h001;
    if (dtick && st.idle_cnt != TIMEOUT_CYC)
      nx.idle_cnt = st.idle_cnt + 10'h001;
    if (fall)
      nx.idle_cnt = '0;
    if (cmd_done)
    begin
      nx.cmd_first = 1'b1;
      nx.discard   = 1'b0;
    end
    unique case (st.state)
      S_IDLE:
      begin
        // Only a host edge opens a bit; the target never starts one
        if (fall)
        begin
          nx.cnt = '0;
          if (st.tx_active || (tx_out.valid && st.nbits == '0))
          begin
            nx.state = S_TX;
            if (!st.tx_active)
            begin
              nx.shift     = tx_out.data;
              nx.pop       = 1'b1;
              nx.tx_active = 1'b1;
            end
            if (!tx_byte[7])
            begin
              nx.pin_out = 1'b0;
              nx.pin_oe  = 1'b1;
            end
          end
          else
            nx.state = S_RX;
        end
        else if (!st.level && hit(st.cnt, SYNC_MIN_CYC, dtick))
        begin
          nx.state     = S_SYNC_LOW;
          nx.nbits     = '0;
          nx.tx_active = 1'b0;
          nx.discard   = 1'b0;
          nx.cmd_first = 1'b1;
          nx.flush     = 1'b1;
        end
      end
      S_RX:
      begin
        nx.pin_oe = 1'b0;
        if (hit(st.cnt, SAMPLE_CYC, dtick))
        begin
          nx.shift = rx_byte;
          nx.nbits = st.nbits + 3'h1;
          nx.state = S_IDLE;
          if (st.nbits == LAST_BIT)
          begin
            nx.rx_data = rx_byte;
            if (st.cmd_first)
            begin
              nx.cmd_first = 1'b0;
              nx.rx_cmd    = 1'b1;
              // Refused commands are swallowed until cmd_done, a rate probe or a timeout
              if (halt_only(rx_byte) && !halted)
              begin
                nx.discard      = 1'b1;
                nx.cmd_rejected = 1'b1;
              end
              else
                nx.rx_valid = 1'b1;
              if (rx_byte == BACKGROUND_CODE)
                nx.wake_request = 1'b1;
            end
            else
            begin
              nx.rx_cmd   = 1'b0;
              nx.rx_valid = !st.discard;
            end
          end
        end
      end
      S_TX:
      begin
        if (!st.shift[7] && hit(st.cnt, ZERO_LOW_CYC, dtick))
        begin
          nx.pin_out = 1'b1;
          nx.state   = S_SPEED;
        end
        else if (st.shift[7] && hit(st.cnt, ONE_PULSE_CYC, dtick))
        begin
          nx.pin_out = 1'b1;
          nx.pin_oe  = 1'b1;
          nx.state   = S_SPEED;
        end
      end
      S_SPEED:
      begin
        // High drive lasts one clock so it never fights the host
        nx.pin_out = 1'b0;
        nx.pin_oe  = 1'b0;
        nx.shift   = {st.shift[6:0], 1'b0};
        nx.nbits   = st.nbits + 3'h1;
        nx.state   = S_IDLE;
        if (st.nbits == LAST_BIT)
          nx.tx_active = 1'b0;
      end
      S_SYNC_LOW:
      begin
        if (st.level)
        begin
          nx.cnt   = '0;
          nx.state = S_SYNC_WAIT;
        end
      end
      S_SYNC_WAIT:
      begin
        if (hit(st.cnt, SYNC_DELAY_CYC, dtick))
        begin
          nx.cnt     = '0;
          nx.pin_out = 1'b0;
          nx.pin_oe  = 1'b1;
          nx.state   = S_SYNC_RESP;
        end
      end
      S_SYNC_RESP:
      begin
        if (hit(st.cnt, SYNC_RESP_CYC, dtick))
        begin
          nx.pin_out = 1'b1;
          nx.state   = S_SYNC_END;
        end
      end
      S_SYNC_END:
      begin
        nx.pin_out = 1'b0;
        nx.pin_oe  = 1'b0;
        nx.state   = S_IDLE;
      end
    endcase
    // A probe request may outlast the timeout; its state is kept
    if (hit(st.idle_cnt, TIMEOUT_CYC, dtick) && !fall)
    begin
      nx.timeout_abort = 1'b1;
      nx.nbits         = '0;
      nx.tx_active     = 1'b0;
      nx.discard       = 1'b0;
      nx.cmd_first     = 1'b1;
      nx.flush         = 1'b1;
      if (st.state inside {S_RX, S_TX, S_SPEED})
      begin
        nx.state   = S_IDLE;
        nx.pin_out = 1'b0;
        nx.pin_oe  = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st           <= '0;
      st.sync      <= 3'h7;
      st.level     <= 1'b1;
      st.idle_cnt  <= TIMEOUT_CYC;
      st.cmd_first <= 1'b1;
    end
    else
      st <= nx;
  end

  assign debug_pin_out    = st.pin_out;
  assign debug_pin_oe     = st.pin_oe;
  assign start_halted     = st.start_halted;
  assign watchdog_disable = st.watchdog_disable;
  assign wake_request     = st.wake_request;
  assign rx_data          = st.rx_data;
  assign rx_valid         = st.rx_valid;
  assign rx_cmd           = st.rx_cmd;
  assign cmd_rejected     = st.cmd_rejected;
  assign timeout_abort    = st.timeout_abort;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sample_point_a: assert property (
    (st.state == S_RX) && hit(st.cnt, SAMPLE_CYC, dtick)
    |=> (st.shift[0] == $past(st.level)) && (st.state == S_IDLE))
    else $error("host bit not taken at cycle ten");

  bit_start_a: assert property (
    (st.state == S_IDLE) && fall
    |=> (st.cnt == '0) && (st.state inside {S_RX, S_TX}))
    else $error("bit start not restarted on edge");

  zero_low_a: assert property (
    (st.state == S_TX) && !st.shift[7]
    |-> st.pin_oe && !st.pin_out)
    else $error("zero reply not held low");

  zero_edge_a: assert property (
    (st.state == S_TX) && !st.shift[7]
    && hit(st.cnt, ZERO_LOW_CYC, dtick)
    |=> (st.pin_oe && st.pin_out) ##1 !st.pin_oe)
    else $error("zero reply speedup misplaced");

  one_pulse_a: assert property (
    (st.state == S_TX) && st.shift[7]
    && hit(st.cnt, ONE_PULSE_CYC, dtick)
    |=> st.pin_oe && st.pin_out)
    else $error("one reply speedup missing at cycle seven");

  one_quiet_a: assert property (
    (st.state == S_TX) && st.shift[7] |-> !st.pin_oe)
    else $error("pin driven before one speedup");

  rx_release_a: assert property (
    (st.state == S_RX) |=> !st.pin_oe)
    else $error("pin driven while host sends");

  bit_length_a: assert property (
    (st.state == S_TX) |-> (st.cnt < BIT_CYCLES))
    else $error("reply bit overruns bit time");

  timeout_fire_a: assert property (
    hit(st.idle_cnt, TIMEOUT_CYC, dtick) && !fall
    |=> st.timeout_abort && (st.nbits == '0) && st.cmd_first)
    else $error("timeout did not abort");

  halt_only_a: assert property (
    st.cmd_rejected
    |-> !$past(halted) && !st.rx_data[7] && !st.rx_valid)
    else $error("wrong command refused");

  wdog_off_a: assert property (
    halted |=> st.watchdog_disable)
    else $error("watchdog not held off");

  msb_shift_a: assert property (
    (st.state == S_SPEED) |=> (st.shift == ($past(st.shift) << 1)))
    else $error("reply not shifted msb first");

  speedup_short_a: assert property (
    st.pin_oe && st.pin_out |=> !st.pin_oe)
    else $error("high drive longer than one clock");

  probe_resp_a: assert property (
    (st.state == S_SYNC_RESP) |-> st.pin_oe && !st.pin_out)
    else $error("probe answer not driven low");

  rx_byte_c: cover property (st.rx_valid && !st.rx_cmd);
  tx_byte_c: cover property ((st.state == S_SPEED) && (st.nbits == LAST_BIT));
  probe_c: cover property (st.state == S_SYNC_END);
  refuse_c: cover property (st.cmd_rejected);

endmodule

// ---- bdl_link_tb.sv ----
// Self-checking bench for the single-wire debug bit link
`timescale 1ns/10ps
module bdl_link_tb
  import bdl_pkg::*;
  ;
  logic        ref_clk = 1'b0;
  logic        rst, debug_clock_source_select, halted, cmd_done;
  logic        alt_clk_tick = 1'b0;
  logic        tx_valid, debug_pin_out, debug_pin_oe, start_halted, watchdog_disable;
  logic        wake_request, rx_valid, rx_cmd, cmd_rejected, timeout_abort, tx_ready;
  logic        host_oe, host_out, sending, rd_done, rd_ok;
  logic        spd_q = 1'b0;
  logic        pin_q = 1'b1;
  logic [7:0]  tx_data, rx_data, rd_data;
  logic [7:0]  tx_q[$];
  logic [10:0] rx_q[$], e;
  logic [31:0] seed = 32'h7FF48F4E;
  int          fails = 0, comparisons = 0, cyc = 0, last_fall = 0;
  int          ab_cnt = 0, ab_gap = 0, n, len, a0;
  wire         debug_pin;

  // Pull-up wins when neither side drives
  assign debug_pin = debug_pin_oe ? debug_pin_out : (host_oe ? host_out : 1'b1);

  always #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) alt_clk_tick <= ~alt_clk_tick;

  bdl_link bdl_link_i (
    .ref_clk(ref_clk), .rst(rst), .debug_pin_in(debug_pin),
    .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
    .debug_clock_source_select(debug_clock_source_select), .alt_clk_tick(alt_clk_tick),
    .halted(halted), .start_halted(start_halted), .watchdog_disable(watchdog_disable),
    .wake_request(wake_request), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_cmd(rx_cmd), .cmd_rejected(cmd_rejected), .cmd_done(cmd_done),
    .timeout_abort(timeout_abort), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));

  bdl_host_model bdl_host_model_i (
    .ref_clk(ref_clk), .pin(debug_pin), .tgt_oe(debug_pin_oe), .tgt_out(debug_pin_out),
    .host_oe(host_oe), .host_out(host_out), .sending(sending), .rd_done(rd_done),
    .rd_ok(rd_ok), .rd_data(rd_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // f is {rejected, wake, command}; keep=0 means the byte must vanish
  task automatic rx(input logic [7:0] b, input logic [2:0] f, input logic keep, input int t);
    if (keep)
      rx_q.push_back({f, b});
    bdl_host_model_i.send_bits(b, 8, t);
  endtask

  task automatic next_cmd();
    cmd_done = 1'b1;
    @(negedge ref_clk);
    cmd_done = 1'b0;
  endtask

  // Outputs settle a little after the falling edge that the drivers use
  always @(negedge ref_clk)
  begin
    #1;
    cyc++;
    if (debug_pin === 1'b0 && pin_q === 1'b1)
      last_fall = cyc;
    pin_q = debug_pin;
    if (timeout_abort === 1'b1)
    begin
      ab_cnt++;
      ab_gap = cyc - last_fall;
    end
    if (spd_q)
      check(debug_pin_oe & debug_pin_out, 1'b0);
    spd_q = debug_pin_oe & debug_pin_out;
    if (sending)
      check(debug_pin_oe, 1'b0);
    if (rx_valid === 1'b1 || cmd_rejected === 1'b1)
    begin
      e = (rx_q.size() > 0) ? rx_q.pop_front() : 11'h7FF;
      if (e[10])
        check({cmd_rejected, wake_request}, e[10:9]);
      else
        check({cmd_rejected, wake_request, rx_cmd, rx_data}, e);
    end
    if (rd_done)
    begin
      e = (tx_q.size() > 0) ? {3'h0, tx_q.pop_front()} : 11'h7FF;
      check({3'h0, rd_data}, e);
      check(rd_ok, 1'b1);
    end
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    $display("watchdog expired");
    fails++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    debug_clock_source_select = 1'b0;
    halted = 1'b0;
    cmd_done = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(start_halted, 1'b0);
    check(tx_ready, 1'b1);
    halted = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(watchdog_disable, 1'b1);
    halted = 1'b0;
    bdl_host_model_i.drive(1'b1, 1'b0);
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(start_halted, 1'b1);
    check(watchdog_disable, 1'b0);
    bdl_host_model_i.drive(1'b0, 1'b1);
    repeat (600) @(negedge ref_clk);
    $display("test done: reset");
    rx(8'hE4, 3'h1, 1'b1, 1);
    seed = xs(seed);
    rx(seed[7:0], 3'h0, 1'b1, 1);
    next_cmd();
    rx(BACKGROUND_CODE, 3'h3, 1'b1, 1);
    next_cmd();
    rx(8'h08, 3'h4, 1'b1, 1);
    rx(8'h33, 3'h0, 1'b0, 1);
    next_cmd();
    halted = 1'b1;
    rx(8'h08, 3'h1, 1'b1, 1);
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      rx(seed[7:0], 3'h0, 1'b1, 1);
    end
    $display("test done: commands");
    next_cmd();
    n = 0;
    for (int i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      if (tx_ready === 1'b1)
      begin
        tx_q.push_back(seed[7:0]);
        n++;
      end
      tx_valid = 1'b1;
      tx_data = seed[7:0];
      @(negedge ref_clk);
    end
    tx_valid = 1'b0;
    check(11'(n), 11'h004);
    check(tx_ready, 1'b0);
    repeat (4) bdl_host_model_i.read_byte();
    @(negedge ref_clk);
    check(tx_ready, 1'b1);
    $display("test done: replies");
    a0 = ab_cnt;
    bdl_host_model_i.send_bits(8'hA0, 3, 1);
    for (int i = 0; i < 700 && ab_cnt == a0; i++)
      @(negedge ref_clk);
    check(11'(ab_cnt - a0), 11'h001);
    check(11'(ab_gap >= 513 && ab_gap <= 517), 11'h001);
    rx(8'hE8, 3'h1, 1'b1, 1);
    $display("test done: timeout");
    next_cmd();
    debug_clock_source_select = 1'b1;
    rx(8'hC4, 3'h1, 1'b1, 2);
    seed = xs(seed);
    rx(seed[7:0], 3'h0, 1'b1, 2);
    debug_clock_source_select = 1'b0;
    $display("test done: alternate clock");
    bdl_host_model_i.probe(len);
    check(11'(len), 11'h080);
    next_cmd();
    rx(8'hE4, 3'h1, 1'b1, 1);
    $display("test done: rate probe");
    check(11'(rx_q.size() + tx_q.size()), 11'h000);
    complete_run();
  end
endmodule

// ---- bdl_pkg.sv ----
// Shared constants and types for the single-wire debug bit link
package bdl_pkg;

  localparam int               BYTE_BITS      = 8;
  localparam int               FIFO_DEPTH     = 4;
  localparam int               CNT_W          = 10;
  localparam logic [CNT_W-1:0] CNT_MAX        = 10'h3FF;
  localparam logic [CNT_W-1:0] BIT_CYCLES     = 10'h010;
  localparam logic [CNT_W-1:0] SAMPLE_CYC     = 10'h00A;
  localparam logic [CNT_W-1:0] ONE_PULSE_CYC  = 10'h007;
  localparam logic [CNT_W-1:0] ZERO_LOW_CYC   = 10'h00D;
  localparam logic [CNT_W-1:0] TIMEOUT_CYC    = 10'h200;
  localparam logic [CNT_W-1:0] SYNC_MIN_CYC   = 10'h080;
  localparam logic [CNT_W-1:0] SYNC_DELAY_CYC = 10'h010;
  localparam logic [CNT_W-1:0] SYNC_RESP_CYC  = 10'h080;
  localparam logic [7:0]       BACKGROUND_CODE = 8'h90;
  localparam logic [2:0]       LAST_BIT       = 3'h7;
  localparam logic [1:0]       MODE_SETTLE    = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_TX,
    S_SPEED,
    S_SYNC_LOW,
    S_SYNC_WAIT,
    S_SYNC_RESP,
    S_SYNC_END
  } bdl_state_e;

endpackage

// ---- bdl_stream_if.sv ----
// Valid/ready byte stream between the link and its reply buffer
`timescale 1ns/10ps
interface bdl_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
